// ### src/cpm_mode_ctrl.sv
/*
 Charger power-mode controller with an APB register slave.
 Assumes comparator outputs and pins arrive asynchronous and are
 resynchronised here; the analog loops act on the enables driven out.
*/
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cpm_mode_ctrl
    import cpm_pkg::*;
#(
    parameter int unsigned SC_REC_CYCLES  = SC_REC_CYC,
    parameter int unsigned HOST_UP_CYCLES = HOST_UP_CYC,
    parameter int unsigned MON_CYCLES     = MON_CYC,
    parameter int unsigned WAKE1_CYCLES   = 500_000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        input_valid,
    input  wire logic        input_above_sleep,
    input  wire logic        bat_above_lock,
    input  wire logic        bat_above_top_lock,
    input  wire logic        short_limit,
    input  wire logic        rail_good,
    input  wire logic        charge_disable_n_pin,
    input  wire logic        manual_button_n,
    input  wire logic        load_switch_pin,
    input  wire logic [4:0]  battery_level_sample,
    output logic             discharge_fet_on,
    output logic             charge_enable,
    output logic             main_rail_enable,
    output logic             aux_output,
    output logic             input_isolate,
    output logic             serial_enable,
    output logic             host_if_ready,
    output logic             irq_pulse,
    output logic [2:0]       battery_lockout_level
);

    cpm_sense_t raw;
    cpm_sync_t  sy_reg, sy_next;
    cpm_state_t st_reg, st_next;
    cpm_sense_t s;
    logic       wr, rd, hit;

    assign raw = '{input_valid, input_above_sleep, bat_above_lock,
                   bat_above_top_lock, short_limit, rail_good,
                   charge_disable_n_pin, manual_button_n, load_switch_pin};
    assign s = sy_reg.fast;

    // Three-stage sampling; a change counts once stages two and three agree
    always_comb begin
        sy_next = sy_reg;
        sy_next.s0 = 3'h0;
        sy_next.s1 = 3'h0;
        sy_next.s2 = 3'h0;
        sy_next.stable = 3'h0;
        sy_next.fast = sy_reg.fast;
    end

    logic [8:0] p1_reg, p2_reg, p3_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_reg <= 9'h000;
            p2_reg <= 9'h000;
            p3_reg <= 9'h000;
            sy_reg <= '0;
        end else begin
            p1_reg <= raw;
            p2_reg <= p1_reg;
            p3_reg <= p2_reg;
            sy_reg <= sy_next;
            for (int i = 0; i < 9; i++) begin
                if (p2_reg[i] == p3_reg[i]) begin
                    sy_reg.fast[i] <= p3_reg[i];
                end
            end
        end
    end

    function automatic logic mon_in_range(input logic [4:0] c);
        return (c <= MON_CODE_MAX);
    endfunction

    assign wr  = psel && penable && pwrite;
    assign rd  = psel && penable && !pwrite;
    assign hit = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) ||
                 (paddr == FAULT_ADDR) || (paddr == MON_ADDR);

    always_comb begin
        st_next = st_reg;
        st_next.cd_prev = s.cd_pin;
        st_next.mode_cnt = st_reg.mode_cnt + 25'd1;
        st_next.fault_read = 1'b0;
        st_next.sc_cnt = 12'd0;
        if (st_reg.irq_cnt != 11'd0) begin
            st_next.irq_cnt = st_reg.irq_cnt - 11'd1;
        end
        // Host side becomes usable a fixed time after the rail is good
        if (!s.rail_good) begin
            st_next.up_cnt = 16'h0000;
            st_next.host_ready = 1'b0;
        end else if (st_reg.up_cnt >= 16'(HOST_UP_CYCLES - 1)) begin
            st_next.host_ready = 1'b1;
        end else begin
            st_next.up_cnt = st_reg.up_cnt + 16'd1;
        end
        // Pin toggle restores a serial link switched off by hold request
        if (s.cd_pin != st_reg.cd_prev) begin
            st_next.serial_off = 1'b0;
        end

        // Register writes, only when the serial link is alive
        if (wr && serial_enable) begin
            if (paddr == CTRL_ADDR) begin
                st_next.ctrl = pwdata[7:0];
                st_next.lock_sel = pwdata[CTRL_LOCK_LSB +: 3];
                if (!pwdata[CTRL_SHIP_BIT] && s.input_valid) begin
                    st_next.ship_pend = 1'b0;
                end
                if (pwdata[CTRL_SHIP_BIT]) begin
                    st_next.ship_pend = 1'b1;
                end
                if (pwdata[CTRL_HOLD_BIT] && !s.input_valid) begin
                    st_next.serial_off = 1'b1;
                end
                if (pwdata[CTRL_TRIG_BIT] && !st_reg.mon_busy) begin
                    st_next.mon_busy = 1'b1;
                    st_next.mon_cnt = 16'h0000;
                end
            end
        end
        if (rd && (paddr == FAULT_ADDR)) begin
            st_next.fault_read = 1'b1;
        end

        // Monitor sample completes after the settling time
        if (st_reg.mon_busy) begin
            st_next.ctrl[CTRL_TRIG_BIT] = 1'b0;
            if (st_reg.mon_cnt >= 16'(MON_CYCLES - 1)) begin
                st_next.mon_busy = 1'b0;
                st_next.mon_code = mon_in_range(battery_level_sample) ?
                    battery_level_sample : MON_CODE_MAX;
            end else begin
                st_next.mon_cnt = st_reg.mon_cnt + 16'd1;
            end
        end

        // Sleep fault clears only after a read with the condition gone
        if (st_reg.fault_read && st_reg.mode != CPM_ST_SLEEP) begin
            st_next.fault_sleep = 1'b0;
            st_next.fault_sc = 1'b0;
        end

        // Button held for the wake time, counted while in ship
        if (s.button_n) begin
            st_next.btn_held = 1'b0;
        end

        case (st_reg.mode)
            CPM_ST_SHIP: begin
                if (!s.button_n &&
                    st_reg.mode_cnt >= 25'(WAKE1_CYCLES - 1)) begin
                    st_next.btn_held = 1'b1;
                end
                if (s.button_n && st_reg.btn_held) begin
                    st_next.btn_held = 1'b0;
                end
                if (!s.button_n == 1'b0 && !st_reg.btn_held) begin
                    st_next.mode_cnt = 25'd0;
                end
                if ((s.input_valid || (s.button_n && st_reg.btn_held)) &&
                    s.bat_above_top_lock) begin
                    st_next.mode = CPM_ST_ACTIVE;
                    st_next.ship_pend = 1'b0;
                    st_next.ctrl[CTRL_SHIP_BIT] = 1'b0;
                    st_next.mode_cnt = 25'd0;
                end
            end
            CPM_ST_SCOFF: begin
                if (st_reg.mode_cnt >= 25'(SC_REC_CYCLES - 1)) begin
                    st_next.mode = CPM_ST_ACTIVE;
                    st_next.mode_cnt = 25'd0;
                end
            end
            CPM_ST_SLEEP: begin
                if (s.input_above_sleep || !s.input_valid) begin
                    st_next.mode = s.input_valid ? CPM_ST_CHARGE :
                                   CPM_ST_ACTIVE;
                    st_next.mode_cnt = 25'd0;
                end
            end
            default: begin
                // Ship entry needs the pin high and the input gone
                if (st_reg.ship_pend && s.cd_pin && !s.input_valid) begin
                    st_next.mode = CPM_ST_SHIP;
                    st_next.mode_cnt = 25'd0;
                end else if (s.input_valid && !s.input_above_sleep) begin
                    st_next.mode = CPM_ST_SLEEP;
                    st_next.fault_sleep = 1'b1;
                    st_next.irq_cnt = 11'(IRQ_CYC);
                    st_next.mode_cnt = 25'd0;
                end else if (s.input_valid) begin
                    st_next.mode = (s.cd_pin || st_reg.ctrl[CTRL_CHG_OFF]) ?
                        CPM_ST_CHGOFF : CPM_ST_CHARGE;
                end else if (!s.cd_pin || st_reg.ctrl[CTRL_HOLD_BIT]) begin
                    if (st_reg.mode != CPM_ST_HOLD) begin
                        st_next.mode = CPM_ST_HOLD;
                        st_next.aux_latched = st_reg.ctrl[CTRL_AUX_BIT];
                        st_next.mon_busy = 1'b1;
                        st_next.mon_cnt = 16'h0000;
                        st_next.mode_cnt = 25'd0;
                    end
                end else begin
                    if (st_reg.mode != CPM_ST_ACTIVE) begin
                        st_next.mode_cnt = 25'd0;
                    end
                    st_next.mode = CPM_ST_ACTIVE;
                    // Short time counts on its own, not from mode entry
                    if (s.short_limit && st_reg.mode == CPM_ST_ACTIVE) begin
                        st_next.sc_cnt = st_reg.sc_cnt + 12'd1;
                    end
                    if (s.short_limit &&
                        st_reg.sc_cnt >= 12'(SC_DGL_CYC - 1)) begin
                        st_next.mode = CPM_ST_SCOFF;
                        st_next.fault_sc = 1'b1;
                        st_next.mode_cnt = 25'd0;
                        st_next.sc_cnt = 12'd0;
                    end else if (st_reg.mode == CPM_ST_ACTIVE &&
                                 st_reg.mode_cnt >= 25'(RAIL_DGL_CYC)) begin
                        st_next.mode_cnt = 25'(RAIL_DGL_CYC);
                    end
                end
            end
        endcase
        // Event set wins over read clear
        if (st_next.mode == CPM_ST_SLEEP) begin
            st_next.fault_sleep = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.mode <= CPM_ST_HOLD;
            st_reg.ctrl <= CTRL_RESET;
            st_reg.lock_sel <= LOCK_SEL_RESET;
        end else begin
            st_reg <= st_next;
            if (rd) begin
                if (paddr == CTRL_ADDR) begin
                    st_reg.prdata <= {21'h0, st_reg.lock_sel,
                                      st_reg.ctrl};
                end else if (paddr == STATUS_ADDR) begin
                    st_reg.prdata <= {24'h0, st_reg.host_ready,
                                      st_reg.mode};
                end else if (paddr == FAULT_ADDR) begin
                    st_reg.prdata <= {30'h0, st_reg.fault_sc,
                                      st_reg.fault_sleep};
                end else if (paddr == MON_ADDR) begin
                    st_reg.prdata <= {26'h0, st_reg.mon_busy,
                                      st_reg.mon_code};
                end else begin
                    st_reg.prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Zero-wait slave: read data comes combinationally from live state
    always_comb begin
        if (paddr == CTRL_ADDR) begin
            prdata = {21'h0, st_reg.lock_sel, st_reg.ctrl};
        end else if (paddr == STATUS_ADDR) begin
            prdata = {24'h0, st_reg.host_ready, st_reg.mode};
        end else if (paddr == FAULT_ADDR) begin
            prdata = {30'h0, st_reg.fault_sc, st_reg.fault_sleep};
        end else if (paddr == MON_ADDR) begin
            prdata = {26'h0, st_reg.mon_busy, st_reg.mon_code};
        end else begin
            prdata = 32'h0000_0000;
        end
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!hit || !serial_enable);

    // Battery-fed modes keep the discharge FET on; short recovery drops it
    assign discharge_fet_on = (st_reg.mode == CPM_ST_ACTIVE) ||
                              (st_reg.mode == CPM_ST_HOLD) ||
                              (st_reg.mode == CPM_ST_SLEEP);
    assign main_rail_enable = (st_reg.mode != CPM_ST_SHIP) &&
                              (st_reg.mode != CPM_ST_SCOFF) &&
                              !(st_reg.mode == CPM_ST_ACTIVE &&
                                st_reg.mode_cnt < 25'(RAIL_DGL_CYC)) &&
                              s.bat_above_lock;
    assign charge_enable    = (st_reg.mode == CPM_ST_CHARGE);
    assign input_isolate    = (st_reg.mode == CPM_ST_SLEEP) ||
                              (st_reg.mode == CPM_ST_SHIP);
    assign aux_output = (st_reg.mode == CPM_ST_HOLD) ?
                        (s.ls_pin || st_reg.aux_latched) :
                        (st_reg.mode != CPM_ST_SHIP) &&
                        st_reg.ctrl[CTRL_AUX_BIT];
    assign serial_enable = !st_reg.serial_off &&
                           st_reg.mode != CPM_ST_SHIP;
    assign host_if_ready = st_reg.host_ready;
    assign irq_pulse     = (st_reg.irq_cnt != 11'd0);
    assign battery_lockout_level = st_reg.lock_sel;

endmodule
`default_nettype wire

// ### src/cpm_pkg.sv
/*
 Package for the charger power-mode control block: register offsets,
 field positions, reset values, timing constants and the state types.
 Assumes a 10 MHz APB clock and analog comparators outside the block.
*/
// Notes on behaviour
// - Ship mode latched off; wake by input or button
// - Ship needs disable pin high; waits input removal
// - Ship exit refused unless battery above top lockout
// - Host may cancel pending ship while input valid
// - In ship only input comparator and button live
// - Hold mode: rail from battery, button and switch live
// - Load switch pin or prior host enable keeps aux on
// - Disable pin and input select hold/charge/active modes
// - Hold request on battery disables serial; pin toggle restores
// - Battery attach: discharge FET on, rail after deglitch
// - Short persists: FET off recovery time, then retry
// - Short deglitch 250 us, recovery 2 s
// - Battery lockout selectable, fixed 100 mV hysteresis
// - Charge stops on pin high or enable bit off
// - Host interfaces live 5 ms after rail good
// - Sample battery level before entering hold mode; the sample starts on hold entry, result in hold
// - Trigger bit starts sample; result valid after 2 ms
// - Level reported 60 to 100 percent in 2 percent steps
// - Sleep when input below sleep level above lockout
// - Sleep entry: FET on, 128 us pulse, fault bits
// - Input above battery plus offset ends sleep, recharge
// - Sleep fault stays until read and condition gone
package cpm_pkg;

    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned SC_DGL_US     = 250;
    localparam int unsigned SC_REC_S      = 2;
    localparam int unsigned IRQ_PULSE_US  = 128;
    localparam int unsigned HOST_UP_MS    = 5;
    localparam int unsigned MON_SETTLE_MS = 2;
    localparam int unsigned RAIL_DGL_US   = 350;
    localparam int unsigned SC_DGL_CYC    = SC_DGL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SC_REC_CYC    = SC_REC_S * CLK_HZ;
    localparam int unsigned IRQ_CYC       = IRQ_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HOST_UP_CYC   = HOST_UP_MS * (CLK_HZ / 1_000);
    localparam int unsigned MON_CYC       = MON_SETTLE_MS * (CLK_HZ / 1_000);
    localparam int unsigned RAIL_DGL_CYC  = RAIL_DGL_US * (CLK_HZ / 1_000_000);

    // Register byte offsets
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] FAULT_ADDR  = 8'h08;
    localparam logic [7:0] MON_ADDR    = 8'h0c;

    // Control register fields
    localparam int unsigned CTRL_SHIP_BIT   = 0;
    localparam int unsigned CTRL_HOLD_BIT   = 1;
    localparam int unsigned CTRL_CHG_OFF    = 2;
    localparam int unsigned CTRL_AUX_BIT    = 3;
    localparam int unsigned CTRL_TRIG_BIT   = 4;
    localparam int unsigned CTRL_LOCK_LSB   = 8;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [2:0]  LOCK_SEL_RESET  = 3'h0;
    localparam logic [2:0]  LOCK_SEL_MAX    = 3'h7;

    // Fault register fields
    localparam int unsigned FAULT_SLEEP_BIT = 0;
    localparam int unsigned FAULT_SC_BIT    = 1;

    // Monitor: code 0 is below 60 percent, codes 1..21 are 60..100
    localparam logic [4:0] MON_CODE_MAX = 5'h15;

    typedef enum logic [6:0] {
        CPM_ST_HOLD   = 7'b0000001,
        CPM_ST_ACTIVE = 7'b0000010,
        CPM_ST_CHARGE = 7'b0000100,
        CPM_ST_CHGOFF = 7'b0001000,
        CPM_ST_SLEEP  = 7'b0010000,
        CPM_ST_SHIP   = 7'b0100000,
        CPM_ST_SCOFF  = 7'b1000000
    } cpm_mode_t;

    typedef struct packed {
        logic       input_valid;
        logic       input_above_sleep;
        logic       bat_above_lock;
        logic       bat_above_top_lock;
        logic       short_limit;
        logic       rail_good;
        logic       cd_pin;
        logic       button_n;
        logic       ls_pin;
    } cpm_sense_t;

    typedef struct packed {
        logic [2:0] s0;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] stable;
        cpm_sense_t fast;
    } cpm_sync_t;

    typedef struct packed {
        cpm_mode_t  mode;
        logic [7:0] ctrl;
        logic [2:0] lock_sel;
        logic       fault_sleep;
        logic       fault_sc;
        logic       fault_read;
        logic       serial_off;
        logic       cd_prev;
        logic       ship_pend;
        logic       aux_latched;
        logic       btn_held;
        logic [24:0] mode_cnt;
        logic [11:0] sc_cnt;
        logic [15:0] mon_cnt;
        logic       mon_busy;
        logic [4:0] mon_code;
        logic [10:0] irq_cnt;
        logic [15:0] up_cnt;
        logic       host_ready;
        logic [31:0] prdata;
    } cpm_state_t;

endpackage

// ### test/cpm_env_model.sv
/*
 Far-side model: comparators, pins and battery level monitor.
 Assumes the bench sets every wanted level in one sense struct.
*/
`timescale 1ns/100ps
`default_nettype none
module cpm_env_model
    import cpm_pkg::*;
#(
    parameter logic [4:0] LEVEL = 5'h0b
) (
    input  wire cpm_sense_t s,
    output logic       input_valid,
    output logic       input_above_sleep,
    output logic       bat_above_lock,
    output logic       bat_above_top_lock,
    output logic       short_limit,
    output logic       rail_good,
    output logic       charge_disable_n_pin,
    output logic       manual_button_n,
    output logic       load_switch_pin,
    output logic [4:0] battery_level_sample
);
    assign {input_valid, input_above_sleep, bat_above_lock} = s[8:6];
    assign {bat_above_top_lock, short_limit, rail_good} = s[5:3];
    // Pulled down: only a driven high reads high
    assign charge_disable_n_pin = (s.cd_pin === 1'b1);
    assign manual_button_n = s.button_n;
    assign load_switch_pin = (s.ls_pin === 1'b1);
    // Steady level; charge is held still around a sample
    assign battery_level_sample = LEVEL;
endmodule
`default_nettype wire

// ### test/cpm_mode_ctrl_properties.sv
/*
 Checker for the charger power-mode controller, bound to its ports.
 Assumes sense inputs settle through a few sync flops before use.
*/
`timescale 1ns/100ps
`default_nettype none
module cpm_mode_ctrl_chk
    import cpm_pkg::*;
#(
    parameter int unsigned HOST_UP_CYCLES = HOST_UP_CYC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        input_valid,
    input wire logic        input_above_sleep,
    input wire logic        bat_above_top_lock,
    input wire logic        short_limit,
    input wire logic        rail_good,
    input wire logic        charge_disable_n_pin,
    input wire logic        load_switch_pin,
    input wire logic        discharge_fet_on,
    input wire logic        charge_enable,
    input wire logic        aux_output,
    input wire logic        input_isolate,
    input wire logic        serial_enable,
    input wire logic        host_if_ready,
    input wire logic        irq_pulse
);
    logic [15:0] irq_run;
    logic [15:0] sc_run;
    logic [19:0] up_run;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Run lengths; the sync delay is why the short and host-up limits carry slack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_run <= '0;
            sc_run <= '0;
            up_run <= '0;
        end else begin
            irq_run <= irq_pulse ? irq_run + 16'd1 : 16'd0;
            sc_run <= short_limit ? sc_run + 16'd1 : 16'd0;
            if (!rail_good) begin
                up_run <= '0;
            end else if (up_run != '1) begin
                up_run <= up_run + 20'd1;
            end
        end
    end
    property p_serr; psel && penable && !serial_enable |-> pslverr; endproperty
    property p_mon;
        psel && penable && !pwrite && paddr == MON_ADDR
            |-> prdata[4:0] <= MON_CODE_MAX;
    endproperty
    property p_irq_len; $fell(irq_pulse) |-> irq_run == 16'd1280; endproperty
    property p_irq_fet; $rose(irq_pulse) |-> discharge_fet_on; endproperty
    property p_cd; charge_disable_n_pin [*8] |-> !charge_enable; endproperty
    property p_noin; !input_valid [*8] |-> !charge_enable; endproperty
    property p_iso;
        (input_valid && input_above_sleep && bat_above_top_lock) [*8]
            |-> !input_isolate;
    endproperty
    property p_aux;
        (!input_valid && !charge_disable_n_pin && load_switch_pin) [*8]
            |-> aux_output;
    endproperty
    property p_sc; sc_run == 16'd2515 |-> !discharge_fet_on; endproperty
    property p_up; up_run >= HOST_UP_CYCLES + 8 |-> host_if_ready; endproperty
    a_serr: assert property (p_serr) else $error("no slave error");
    a_mon: assert property (p_mon) else $error("level code range");
    a_irq_len: assert property (p_irq_len) else $error("pulse len");
    a_irq_fet: assert property (p_irq_fet) else $error("fet off");
    a_cd: assert property (p_cd) else $error("charge on, pin high");
    a_noin: assert property (p_noin) else $error("charge, no input");
    a_iso: assert property (p_iso) else $error("input isolated");
    a_aux: assert property (p_aux) else $error("aux off");
    a_sc: assert property (p_sc) else $error("short not cut");
    a_up: assert property (p_up) else $error("host if not ready");
    c_irq: cover property (irq_pulse);
    c_sc: cover property (sc_run == 16'd2515);
    c_serr: cover property (psel && penable && pslverr);
endmodule
bind cpm_mode_ctrl cpm_mode_ctrl_chk #(
    .HOST_UP_CYCLES(HOST_UP_CYCLES)
) u_chk (.*);
`default_nettype wire

// ### test/test_charger_power_mode_control.sv
/*
 Testbench: APB tasks and mode scenarios for the power-mode controller.
 Assumes short timer parameters so the whole run stays brief.
*/
`timescale 1ns/100ps
`default_nettype none
module test_charger_power_mode_control;
    import cpm_pkg::*;
    localparam int REC = 50;
    localparam int UP = 20;
    localparam int MON = 20;
    localparam int WAKE = 20;
    localparam logic [4:0] LVL = 5'h0b;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic input_valid, input_above_sleep, bat_above_lock, bat_above_top_lock;
    logic short_limit, rail_good, charge_disable_n_pin, manual_button_n;
    logic load_switch_pin, discharge_fet_on, charge_enable, main_rail_enable;
    logic aux_output, input_isolate, serial_enable, host_if_ready, irq_pulse;
    logic [4:0] battery_level_sample;
    logic [2:0] battery_lockout_level;
    cpm_sense_t s = 9'h0ea; // Battery good, rail good, no input, pins idle
    int failures = 0;
    int cmp_count = 0;
    int n;
    always #50 pclk = ~pclk;
    cpm_mode_ctrl #(
        .SC_REC_CYCLES(REC), .HOST_UP_CYCLES(UP),
        .MON_CYCLES(MON), .WAKE1_CYCLES(WAKE)
    ) u_cpm_mode_ctrl (.*);
    cpm_env_model #(.LEVEL(LVL)) u_env (.*);
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // Idle cycle first, so psel never changes twice in one step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) failures++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    initial begin
        #(20_000 * 100);
        failures++;
        end_sim;
    end
    initial begin
        wt(6);
        presetn <= 1'b1;
        wt(UP + 20);
        rdc(CTRL_ADDR, 32'hffff, 32'h0);
        rdc(STATUS_ADDR, 32'hff, 32'h81);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        s.ls_pin <= 1'b1;
        wt(12);
        chk(aux_output, 1'b1);
        s.ls_pin <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            s.input_valid <= i[1];
            s.cd_pin <= i[0];
            wt(12);
            rdc(STATUS_ADDR, 32'h7f, 32'h1 << i);
            chk(charge_enable, i == 2);
        end
        s.cd_pin <= 1'b0;
        apb(1'b1, CTRL_ADDR, 32'h4);
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h8);
        apb(1'b1, CTRL_ADDR, 32'h0);
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h4);
        apb(1'b1, CTRL_ADDR, 32'h10);
        rdc(MON_ADDR, 32'h20, 32'h20);
        wt(MON + 5);
        rdc(MON_ADDR, 32'h3f, {27'h0, LVL});
        s.input_above_sleep <= 1'b0;
        n = 0;
        while (irq_pulse !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk(input_isolate, 1'b1);
        chk({discharge_fet_on, irq_pulse}, 2'h3);
        rdc(STATUS_ADDR, 32'h7f, 32'h10);
        rdc(FAULT_ADDR, 32'h1, 32'h1);
        wt(1300);
        rdc(FAULT_ADDR, 32'h1, 32'h1);
        s.input_above_sleep <= 1'b1;
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h4);
        rdc(FAULT_ADDR, 32'h1, 32'h1);
        rdc(FAULT_ADDR, 32'h1, 32'h0);
        s.cd_pin <= 1'b1;
        apb(1'b1, CTRL_ADDR, 32'h1);
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h8);
        s.input_valid <= 1'b0;
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h20);
        s.bat_above_top_lock <= 1'b0;
        s.button_n <= 1'b0;
        wt(WAKE + 10);
        s.button_n <= 1'b1;
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h20);
        s.bat_above_top_lock <= 1'b1;
        s.input_valid <= 1'b1;
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h8);
        // Ship request pending with input present, then cancelled
        apb(1'b1, CTRL_ADDR, 32'h1);
        apb(1'b1, CTRL_ADDR, 32'h0);
        s.input_valid <= 1'b0;
        wt(12);
        rdc(STATUS_ADDR, 32'h7f, 32'h2);
        s.short_limit <= 1'b1;
        wt(2520);
        chk(discharge_fet_on, 1'b0);
        rdc(STATUS_ADDR, 32'h7f, 32'h40);
        wt(REC + 5);
        rdc(STATUS_ADDR, 32'h7f, 32'h2);
        chk(discharge_fet_on, 1'b1);
        s.short_limit <= 1'b0;
        wt(12);
        rdc(FAULT_ADDR, 32'h2, 32'h2);
        // Pin must settle first, or its own toggle reopens the link
        s.cd_pin <= 1'b0;
        wt(12);
        apb(1'b1, CTRL_ADDR, 32'h2);
        wt(4);
        chk(serial_enable, 1'b0);
        apb(1'b1, CTRL_ADDR, 32'h0);
        chk(er, 1'b1);
        s.cd_pin <= 1'b1;
        wt(12);
        s.cd_pin <= 1'b0;
        wt(12);
        apb(1'b1, CTRL_ADDR, 32'h0);
        chk({serial_enable, er}, 2'h2);
        end_sim;
    end
endmodule
`default_nettype wire
